// [logic/fm_load_link.sv]
// Fast memory multi-halfword load with link and update-on-write.
// Assumes an APB master, a single-outstanding memory port and a
// register file write port with back-pressure.
`timescale 1ns/1ps
`default_nettype none
module fm_load_link
	import fm_link_pkg::*;
#(
	parameter int FIFO_DEPTH = 32
) (
	input  wire logic              sys_clk_i,   // 50 MHz clock
	input  wire logic              rst_n_i,     // Async reset, low
	input  wire logic              psel_i,      // APB select
	input  wire logic              penable_i,   // APB access phase
	input  wire logic              pwrite_i,    // APB write
	input  wire logic [7:0]        paddr_i,     // APB byte address
	input  wire logic [31:0]       pwdata_i,    // APB write data
	output logic      [31:0]       prdata_o,    // APB read data
	output logic                   pready_o,    // APB ready
	output logic                   pslverr_o,   // APB error
	output logic                   mem_req_o,   // Memory request
	output logic                   mem_we_o,    // Memory write
	output logic      [ADDR_W-1:0] mem_addr_o,  // Memory byte address
	output logic      [HW_W-1:0]   mem_wdata_o, // Memory write data
	input  wire logic              mem_ack_i,   // Memory done
	input  wire logic [HW_W-1:0]   mem_rdata_i, // Memory read data
	input  wire logic              alu_we_i,    // ALU writes a reg
	input  wire logic              alu_upd_i,   // Update option
	input  wire logic [REG_W-1:0]  alu_dest_i,  // ALU destination
	input  wire logic [HW_W-1:0]   alu_data_i,  // ALU result
	output logic                   rf_we_o,     // Reg file write
	output logic      [REG_W-1:0]  rf_addr_o,   // Reg number
	output logic      [HW_W-1:0]   rf_data_o,   // Reg data
	input  wire logic              rf_ready_i,  // Reg file can take
	output logic      [HW_W-1:0]   shadow_o,    // Branch shadow reg
	output logic                   busy_o       // Unit busy
);
	// A whole load must fit the FIFO
	if (FIFO_DEPTH < int'(MAX_HW)) begin : depth_chk
		$error("fm_load_link: FIFO_DEPTH below max count");
	end

	fm_fifo_if #(.WIDTH(HW_W)) ff ();
	fm_fifo #(.WIDTH(HW_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_n_i  (rst_n_i),
		.f        (ff.store)
	);

	fm_state_t         state;
	logic [ADDR_W-1:0] start_reg;
	logic [31:0]       ctrl_reg;
	logic [ADDR_W-1:0] cur_addr;
	logic [CNT_W-1:0]  remain;
	logic              first_hw;
	logic              link_act;
	logic              link_valid;
	logic [19:1]       link_base;
	logic [3:0]        link_mask;
	logic [REG_W-1:0]  link_first;
	logic [CNT_W-1:0]  link_cnt;
	logic [REG_W-1:0]  drain_reg;
	logic              bank_wait;
	logic              upd_pend;
	logic [REG_W-1:0]  upd_dest;
	logic [HW_W-1:0]   upd_data;
	logic              lost;
	logic [HW_W-1:0]   conn_id;
	logic [31:0]       rd_mux;
	logic              addr_hit;
	logic              wr_en;
	logic              go;
	logic              go_ok;
	logic              busy;
	logic [REG_W-1:0]  cmd_rd;
	logic [CNT_W-1:0]  cmd_cnt;
	logic [CNT_W-1:0]  cnt_eff;
	logic              cmd_link;
	logic              cmd_z;
	logic [ADDR_W-1:0] start_addr;
	logic [ADDR_W-1:0] z_mask;
	logic [REG_W-1:0]  upd_off;
	logic              upd_hit;
	logic              upd_done;
	logic              rd_ack;
	logic              pop_fire;
	logic [ADDR_W-1:0] upd_addr;

	// Command fields come from the control write itself
	assign cmd_rd   = pwdata_i[CTRL_RD_POS +: REG_W];
	assign cmd_cnt  = pwdata_i[CTRL_CNT_POS +: CNT_W];
	assign cmd_link = pwdata_i[CTRL_LINK_BIT];
	assign cmd_z    = pwdata_i[CTRL_Z_BIT];
	// Counts above sixteen are clipped rather than overrun
	assign cnt_eff = (cmd_cnt > MAX_HW) ? MAX_HW : cmd_cnt; // [R1]

	// Low bits forced to zero per destination
	always_comb begin
		case (cmd_rd)
			RD_R16:  z_mask = 20'hfffe0; // [R6]
			RD_R24:  z_mask = 20'hffff0;
			RD_R28:  z_mask = 20'hffff8;
			RD_R30:  z_mask = 20'hffffc;
			RD_R31:  z_mask = 20'hffffe;
			default: z_mask = 20'hfffff;
		endcase
	end
	// High nibble and low halfword both come from the start register
	assign start_addr = cmd_z ? (start_reg & z_mask)  // [R6]
		: start_reg;                                  // [R3] [R4] [R5]

	// APB decode; transfers answer in the first access cycle
	assign addr_hit = (paddr_i[1:0] == 2'b00) &&
		(paddr_i == OFS_START || paddr_i == OFS_CTRL ||
		 paddr_i == OFS_STAT || paddr_i == OFS_LINK ||
		 paddr_i == OFS_CONN_ID);
	assign wr_en = psel_i && penable_i && pready_o && pwrite_i &&
		!pslverr_o;
	assign go    = wr_en && paddr_i == OFS_CTRL && pwdata_i[CTRL_GO_BIT];
	assign busy  = state != S_IDLE || upd_pend || ff.pop_valid ||
		bank_wait;
	assign go_ok = go && !busy;

	// Read data mux, sampled in the setup cycle
	always_comb begin
		case (paddr_i)
			OFS_START: rd_mux = {12'h000, start_reg};
			OFS_CTRL:  rd_mux = {1'b0, ctrl_reg[30:0]};
			OFS_STAT:  rd_mux = {29'h0, lost, link_valid, busy};
			OFS_LINK:  rd_mux = {8'h00, link_mask, link_base, 1'b0};
			OFS_CONN_ID: rd_mux = {16'h0000, conn_id};
			default:   rd_mux = 32'h00000000;
		endcase
	end

	// APB answer flops
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end else if (psel_i && !penable_i) begin
			pready_o  <= 1'b1;
			pslverr_o <= !addr_hit;
			prdata_o  <= addr_hit ? rd_mux : 32'h00000000;
		end else begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	// Software-written registers and the identifier
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			start_reg <= '0;
			ctrl_reg  <= 32'h00000000;
			conn_id   <= RST_HW;
		end else if (wr_en) begin
			if (paddr_i == OFS_START)
				start_reg <= pwdata_i[ADDR_W-1:0];
			if (paddr_i == OFS_CTRL)
				ctrl_reg <= pwdata_i;
			if (paddr_i == OFS_CONN_ID)
				conn_id <= {pwdata_i[15:5], pwdata_i[20:16]}; // [R14]
		end
	end

	// Link record; a zero count still sets the link
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			link_valid <= 1'b0;
			link_base  <= '0;
			link_mask  <= 4'h0;
			link_first <= '0;
			link_cnt   <= '0;
		end else if (go_ok && cmd_link) begin
			link_valid <= 1'b1;                           // [R13]
			link_base  <= {start_reg[19:5],
				start_reg[4:1] & cmd_rd[3:0]};            // [R16]
			link_mask  <= ~cmd_rd[3:0];                   // [R15]
			link_first <= cmd_rd;                         // [R8]
			link_cnt   <= cnt_eff;
		end
	end

	// Update hit: ALU wrote one of the linked registers
	assign upd_off  = alu_dest_i - link_first;
	assign upd_hit  = alu_we_i && alu_upd_i && link_valid &&
		upd_off < {1'b0, link_cnt};                       // [R9]
	assign upd_done = state == S_UMW && mem_ack_i;
	assign upd_addr = {link_base[19:5],
		link_base[4:1] | (upd_dest[3:0] & link_mask), 1'b0}; // [R17]

	// One-deep update queue; a new hit wins over the clear
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			upd_pend <= 1'b0;
			upd_dest <= '0;
			upd_data <= RST_HW;
		end else if (upd_hit && (!upd_pend || upd_done)) begin
			upd_pend <= 1'b1;
			upd_dest <= alu_dest_i;
			upd_data <= alu_data_i;
		end else if (upd_done) begin
			upd_pend <= 1'b0;
		end
	end

	// Sticky loss flag: refused start or dropped update
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			lost <= 1'b0;
		else if ((go && busy) || (upd_hit && upd_pend && !upd_done))
			lost <= 1'b1;
		else if (wr_en && paddr_i == OFS_STAT && pwdata_i[STAT_LOST_BIT])
			lost <= 1'b0;
	end

	assign rd_ack = state == S_RD && mem_req_o && mem_ack_i;

	// Memory sequencer; read requests wait for FIFO room
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state       <= S_IDLE;
			mem_req_o   <= 1'b0;
			mem_we_o    <= 1'b0;
			mem_addr_o  <= '0;
			mem_wdata_o <= RST_HW;
			cur_addr    <= '0;
			remain      <= '0;
			first_hw    <= 1'b0;
			link_act    <= 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
					if (upd_pend) begin
						state       <= S_UMW;
						mem_req_o   <= 1'b1;
						mem_we_o    <= 1'b1;
						mem_addr_o  <= upd_addr;    // [R9]
						mem_wdata_o <= upd_data;
					end else if (go_ok && cnt_eff != '0) begin
						state    <= S_RD;
						cur_addr <= start_addr;
						remain   <= cnt_eff;
						first_hw <= 1'b1;
						link_act <= cmd_link;
					end
				end
				S_RD: begin
					if (!mem_req_o && ff.push_ready) begin
						mem_req_o  <= 1'b1;
						mem_we_o   <= 1'b0;
						mem_addr_o <= cur_addr;
					end else if (rd_ack) begin
						mem_req_o <= 1'b0;
						first_hw  <= 1'b0;
						cur_addr  <= cur_addr + HW_STEP; // [R18]
						remain    <= remain - 1'b1;
						if (remain == 5'h01)
							state <= S_IDLE;
					end
				end
				S_UMW: begin
					if (mem_ack_i) begin
						state     <= S_IDLE;
						mem_req_o <= 1'b0;
						mem_we_o  <= 1'b0;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// Fetched halfwords enter the FIFO on acknowledge
	assign ff.push_valid = rd_ack;
	assign ff.push_data  = mem_rdata_i;

	// Shadow copy of the first halfword of a linked load
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			shadow_o <= RST_HW;
		else if (rd_ack && first_hw && link_act)
			shadow_o <= mem_rdata_i;                     // [R10]
	end

	// Upper bank targets stall the first write one cycle
	assign ff.pop_ready = rf_ready_i && !bank_wait;   // [R11]
	assign pop_fire     = ff.pop_valid && ff.pop_ready;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			bank_wait <= 1'b0;
		else if (go_ok && cnt_eff != '0)
			bank_wait <= cmd_rd[REG_W-1];                // [R11]
		else if (ff.pop_valid)
			bank_wait <= 1'b0;
	end

	// Register file writes walk upward from the destination
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drain_reg <= '0;
			rf_we_o   <= 1'b0;
			rf_addr_o <= '0;
			rf_data_o <= RST_HW;
		end else begin
			rf_we_o <= pop_fire;
			if (go_ok)
				drain_reg <= cmd_rd;
			else if (pop_fire) begin
				drain_reg <= drain_reg + 1'b1;           // [R7]
				rf_addr_o <= drain_reg;
				rf_data_o <= ff.pop_data;
			end
		end
	end

	// Busy is shown one cycle after the fact
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			busy_o <= 1'b0;
		else
			busy_o <= busy;
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence read_issue_s;
		state == S_RD && !mem_req_o && ff.push_ready;
	endsequence
	sequence two_acks_s;
		rd_ack && remain > 5'h01;
	endsequence

	start_addr_a: assert property ( // [R3] [R4] [R5] [R6]
		go_ok && cnt_eff != '0 ##1 read_issue_s |=>
			mem_addr_o == $past(start_addr, 2))
		else $error("load start address wrong");
	addr_step_a: assert property ( // [R18]
		two_acks_s ##1 read_issue_s |=>
			mem_addr_o == $past(mem_addr_o, 2) + HW_STEP)
		else $error("halfword address did not step by two");
	shadow_cap_a: assert property ( // [R10]
		rd_ack && first_hw && link_act |=>
			shadow_o == $past(mem_rdata_i))
		else $error("shadow not loaded from first halfword");
	rf_order_a: assert property ( // [R7]
		pop_fire && !go_ok |=> rf_we_o &&
			rf_addr_o == $past(drain_reg) &&
			drain_reg == $past(drain_reg) + 6'h01)
		else $error("register file write out of order");
	zero_count_a: assert property ( // [R13]
		go_ok && cmd_link && cnt_eff == '0 |=>
			link_valid && state == S_IDLE ##1 !mem_req_o)
		else $error("zero count load misbehaved");
	upd_addr_a: assert property ( // [R17]
		state == S_IDLE && upd_pend |=>
			mem_req_o && mem_we_o && mem_addr_o == $past(upd_addr) &&
			mem_wdata_o == $past(upd_data))
		else $error("update address wrong");
	upd_write_a: assert property ( // [R9]
		upd_hit && !upd_pend && !busy |-> ##[1:2] mem_req_o && mem_we_o)
		else $error("update write not issued");
	bank_wait_a: assert property ( // [R11]
		ff.pop_valid && bank_wait |-> !pop_fire ##1 !bank_wait)
		else $error("upper bank extra cycle missing");
	link_mask_a: assert property ( // [R15]
		go_ok && cmd_link |=> link_mask == ~$past(cmd_rd[3:0]))
		else $error("link mask not inverted destination");
	count_cap_a: assert property ( // [R1]
		state == S_RD |-> remain <= MAX_HW && remain != '0)
		else $error("halfword count out of range");
endmodule
`default_nettype wire

// [logic/fm_link_pkg.sv]
// Constants for the fast memory load/link unit.
// Assumes a 50 MHz single clock and an APB register port.
// What this block does
// R1 - Halfword count moves zero to sixteen halfwords
// R2 - Unlinked loads: software aligns items on words
// R3 - Address bits 19:16 from high register
// R4 - Address bits 15:0 from low register
// R5 - Mask bit clear: address used unchanged
// R6 - Mask bit set: zero bits per destination
// R7 - Halfwords fill destination, then next registers
// R8 - Linked load records each register's location
// R9 - Update option writes linked register back
// R10 - Linked load copies first halfword to shadow
// R11 - Upper bank destination costs one cycle
// R12 - Software keeps linked count within destination
// R13 - Zero count load only sets link
// R14 - Connection identifier formed from descriptor address
// R15 - Inverted destination low bits saved as mask
// R16 - Link base from high, low and destination
// R17 - Update address from base, mask, destination
// R18 - Successive halfwords at addresses rising by two
package fm_link_pkg;
	localparam int ADDR_W = 20;
	localparam int HW_W   = 16;
	localparam int CNT_W  = 5;
	localparam int REG_W  = 6;
	localparam logic [CNT_W-1:0] MAX_HW = 5'h10;
	// Register byte offsets
	localparam logic [7:0] OFS_START = 8'h00;
	localparam logic [7:0] OFS_CTRL  = 8'h04;
	localparam logic [7:0] OFS_STAT  = 8'h08;
	localparam logic [7:0] OFS_LINK  = 8'h0c;
	localparam logic [7:0] OFS_CONN_ID = 8'h10;
	// Control fields
	localparam int CTRL_RD_POS   = 0;
	localparam int CTRL_CNT_POS  = 8;
	localparam int CTRL_LINK_BIT = 16;
	localparam int CTRL_Z_BIT    = 17;
	localparam int CTRL_GO_BIT   = 31;
	// Status fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_LINK_BIT = 1;
	localparam int STAT_LOST_BIT = 2;
	// Destinations with a defined alignment mask
	localparam logic [REG_W-1:0] RD_R16 = 6'h10;
	localparam logic [REG_W-1:0] RD_R24 = 6'h18;
	localparam logic [REG_W-1:0] RD_R28 = 6'h1c;
	localparam logic [REG_W-1:0] RD_R30 = 6'h1e;
	localparam logic [REG_W-1:0] RD_R31 = 6'h1f;
	localparam logic [HW_W-1:0] RST_HW = 16'h0000;
	localparam logic [ADDR_W-1:0] HW_STEP = 20'h00002;
	typedef enum logic [1:0] {S_IDLE, S_RD, S_UMW} fm_state_t;
endpackage

// [logic/fm_fifo_if.sv]
// Carrier between the load unit and its halfword FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface fm_fifo_if #(parameter int WIDTH = 16);
	logic             push_valid;
	logic             push_ready;
	logic [WIDTH-1:0] push_data;
	logic             pop_valid;
	logic             pop_ready;
	logic [WIDTH-1:0] pop_data;
	modport store (input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data);
	modport user (output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// [logic/fm_fifo.sv]
// Flip-flop FIFO for fetched halfwords.
// Assumes synchronous push and pop on one clock.
`timescale 1ns/1ps
`default_nettype none
module fm_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic sys_clk_i, // System clock
	input wire logic rst_n_i,   // Async reset, low
	fm_fifo_if.store f          // Push and pop sides
);
	localparam int IW = $clog2(DEPTH);
	// Wrapping indices only work for a power-of-two depth
	if (DEPTH < 2 || (1 << IW) != DEPTH) begin : depth_chk
		$error("fm_fifo: DEPTH must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [IW-1:0]    wr_idx;
	logic [IW-1:0]    rd_idx;
	logic [IW:0]      fill;
	logic             do_push;
	logic             do_pop;

	// Honest flags from the fill level
	assign f.push_ready = (fill != (IW+1)'(DEPTH));
	assign f.pop_valid  = (fill != '0);
	assign f.pop_data   = mem[rd_idx];
	assign do_push = f.push_valid && f.push_ready;
	assign do_pop  = f.pop_valid && f.pop_ready;

	// Storage needs no reset; only the pointers and fill level do
	always_ff @(posedge sys_clk_i) begin
		if (do_push)
			mem[wr_idx] <= f.push_data;
	end

	// Pointers and fill level
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_idx <= '0;
			rd_idx <= '0;
			fill   <= '0;
		end else begin
			if (do_push)
				wr_idx <= wr_idx + 1'b1;
			if (do_pop)
				rd_idx <= rd_idx + 1'b1;
			if (do_push && !do_pop)
				fill <= fill + 1'b1;
			else if (do_pop && !do_push)
				fill <= fill - 1'b1;
		end
	end
endmodule
`default_nettype wire

// [bench/fm_mem_model.sv]
// Behavioural fast memory behind the load unit's memory port.
// Assumes the requester holds req, address and data to the ack edge.
`timescale 1ns/1ps
`default_nettype none
module fm_mem_model (
	input  wire logic        sys_clk_i, // Clock
	input  wire logic        rst_n_i,   // Async reset, low
	input  wire logic        req_i,     // Request level
	input  wire logic        we_i,      // Write request
	input  wire logic [19:0] addr_i,    // Byte address
	input  wire logic [3:0]  lat_i,     // Wait cycles before ack
	output logic             ack_o,     // Done pulse
	output logic      [15:0] rdata_o    // Read data
);
	logic [3:0] wait_cnt;
	// One ack per request; data line scrambled whenever not valid
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_o    <= 1'b0;
			rdata_o  <= 16'h0000;
			wait_cnt <= 4'h0;
		end else if (ack_o) begin
			ack_o    <= 1'b0;
			rdata_o  <= ~rdata_o; // Stale data must never be reused
			wait_cnt <= 4'h0;
		end else if (req_i && wait_cnt >= lat_i) begin
			ack_o   <= 1'b1;
			rdata_o <= we_i ? ~rdata_o : addr_i[16:1] ^ 16'h3c5a;
		end else if (req_i) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// [bench/tb_fm_load_link.sv]
// Self-checking bench for the fast memory load/link unit.
// Assumes the unit answers APB one cycle after setup.
`timescale 1ns/1ps
`default_nettype none
module tb_fm_load_link import fm_link_pkg::*;;
	logic        sys_clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
	logic [7:0]  paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic        pready_o, pslverr_o, mem_req_o, mem_we_o, mem_ack;
	logic [19:0] mem_addr_o;
	logic [15:0] mem_wdata_o, mem_rdata, alu_data_i, rf_data_o, shadow_o;
	logic        alu_we_i, alu_upd_i, rf_we_o, rf_ready_i, busy_o;
	logic [5:0]  alu_dest_i, rf_addr_o;
	logic [3:0]  lat;
	int          cyc, bad_count, tests_run;
	logic [5:0]  rf_a[$];
	logic [15:0] rf_d[$], mem_d[$];
	logic [19:0] mem_a[$];
	logic        mem_w[$];
	int          rf_t[$], ack_t[$];

	fm_load_link #(.FIFO_DEPTH(32)) u_dut (.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
		.alu_we_i(alu_we_i), .alu_upd_i(alu_upd_i),
		.alu_dest_i(alu_dest_i), .alu_data_i(alu_data_i),
		.rf_we_o(rf_we_o), .rf_addr_o(rf_addr_o), .rf_data_o(rf_data_o),
		.rf_ready_i(rf_ready_i), .shadow_o(shadow_o), .busy_o(busy_o));
	fm_mem_model u_mem (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
		.lat_i(lat), .ack_o(mem_ack), .rdata_o(mem_rdata));

	// Clock, 20 ns period
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	// Log register writes and finished memory accesses
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (rf_we_o === 1'b1) begin
			rf_a.push_back(rf_addr_o);
			rf_d.push_back(rf_data_o);
			rf_t.push_back(cyc);
		end
		if (mem_req_o === 1'b1 && mem_ack === 1'b1) begin
			mem_a.push_back(mem_addr_o);
			mem_w.push_back(mem_we_o);
			mem_d.push_back(mem_wdata_o);
			ack_t.push_back(cyc);
		end
	end

	function automatic logic [15:0] hw(input logic [19:0] a);
		return a[16:1] ^ 16'h3c5a; // Same pattern as the memory model
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what,
				got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// One APB transfer; a spare edge keeps back-to-back calls clean
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		psel_i    <= 1'b1;
		pwrite_i  <= wr;
		paddr_i   <= a;
		pwdata_i  <= wd;
		penable_i <= 1'b0;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		do @(posedge sys_clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask

	task automatic clr();
		rf_a.delete(); rf_d.delete(); rf_t.delete(); ack_t.delete();
		mem_a.delete(); mem_w.delete(); mem_d.delete();
	endtask

	// Wait for the sequencer and the register writes to finish
	task automatic settle();
		repeat (3) @(posedge sys_clk_i);
		while (busy_o !== 1'b0) @(posedge sys_clk_i);
		repeat (8) @(posedge sys_clk_i);
	endtask

	// Start one load and judge fetches, writes, shadow and link state
	task automatic load(input logic [5:0] rd, input logic [4:0] n,
		input logic linked, input logic z, input logic [3:0] hi,
		input logic [15:0] lo, input int hold);
		logic [19:0] base, a;
		logic [31:0] v, r;
		logic        e;
		int          m;
		m = rd == RD_R16 ? 5 : rd == RD_R24 ? 4 : rd == RD_R28 ? 3 :
			rd == RD_R30 ? 2 : rd == RD_R31 ? 1 : 0;
		base = {hi, lo};
		if (z) base = base & ~((20'h1 << m) - 20'h1);
		v = 32'h0;
		v[CTRL_RD_POS +: 6] = rd;
		v[CTRL_CNT_POS +: 5] = n;
		v[CTRL_LINK_BIT] = linked;
		v[CTRL_Z_BIT] = z;
		v[CTRL_GO_BIT] = 1'b1;
		clr();
		apb(1'b1, OFS_START, {12'h000, hi, lo}, r, e);
		if (hold > 0) rf_ready_i <= 1'b0;
		apb(1'b1, OFS_CTRL, v, r, e);
		if (hold > 0) begin
			repeat (hold) @(posedge sys_clk_i);
			chk(rf_a.size(), 0, "write while stalled");
			rf_ready_i <= 1'b1;
		end
		settle();
		chk(mem_a.size(), n, "fetch count");
		chk(rf_a.size(), n, "write count");
		for (int k = 0; k < n; k++) begin
			a = base + 20'(2 * k);
			chk(mem_a[k], a, "fetch address");
			chk(rf_a[k], rd + 6'(k), "dest register");
			chk(rf_d[k], hw(a), "dest data");
		end
		if (linked && n > 0) chk(shadow_o, hw(base), "shadow");
		if (linked) begin
			apb(1'b0, OFS_LINK, 32'h0, v, e);
			chk(v, {8'h00, ~rd[3:0], hi, lo[15:5], lo[4:1] & rd[3:0],
				1'b0}, "link base and mask");
		end
	endtask

	// Every masking destination, then plain unmasked loads
	task automatic masks();
		logic [5:0] t[6] = '{6'h10, 6'h18, 6'h1c, 6'h1e, 6'h1f, 6'h05};
		lat <= 4'h0;
		foreach (t[i]) load(t[i], 5'h01, 1'b1, 1'b1, 4'h3, 16'hffff, 0);
		lat <= 4'h3;
		load(6'h10, 5'h10, 1'b0, 1'b0, 4'h9, 16'h1234, 0);
		load(6'h1f, 5'h00, 1'b1, 1'b0, 4'h2, 16'h4442, 0);
		load(6'h00, 5'h10, 1'b0, 1'b0, 4'h1, 16'h0200, 25);
	endtask

	// Upper bank destination costs one more cycle to write
	task automatic bank_cost();
		int d0;
		lat <= 4'h1;
		load(6'h05, 5'h01, 1'b0, 1'b0, 4'h0, 16'h0100, 0);
		d0 = rf_t[0] - ack_t[0];
		load(6'h28, 5'h01, 1'b0, 1'b0, 4'h0, 16'h0100, 0);
		chk(rf_t[0] - ack_t[0], d0 + 1, "upper bank delay");
	endtask

	task automatic alu(input logic [5:0] d, input logic upd,
		input logic [15:0] v);
		alu_we_i   <= 1'b1;
		alu_upd_i  <= upd;
		alu_dest_i <= d;
		alu_data_i <= v;
		@(posedge sys_clk_i);
		alu_we_i <= 1'b0;
		repeat (12) @(posedge sys_clk_i);
	endtask

	// Only a linked register with the update option writes memory
	task automatic update();
		lat <= 4'h2;
		load(6'h18, 5'h06, 1'b1, 1'b0, 4'h0, 16'h8010, 0);
		clr();
		alu(6'h1b, 1'b1, 16'h1234);
		alu(6'h19, 1'b0, 16'h7777);
		alu(6'h28, 1'b1, 16'h5555);
		chk(mem_a.size(), 1, "update count");
		chk(mem_a[0], 20'h08016, "update address");
		chk(mem_w[0], 1'b1, "update is write");
		chk(mem_d[0], 16'h1234, "update data");
	endtask

	// Identifier register and a refused address
	task automatic regs();
		logic [20:0] a;
		logic [31:0] v;
		logic        e;
		a = 21'h03cae0;
		apb(1'b1, OFS_CONN_ID, {11'h000, a}, v, e);
		apb(1'b0, OFS_CONN_ID, 32'h0, v, e);
		chk(v, {16'h0000, a[15:5], a[20:16]}, "identifier");
		apb(1'b0, 8'h14, 32'h0, v, e);
		chk(e, 1'b1, "unmapped error");
		chk(v, 32'h0, "unmapped data");
	endtask

	// A start while busy is refused and latched as lost until cleared
	task automatic refuse();
		logic [31:0] c, v;
		logic        e;
		c = 32'h0;
		c[CTRL_CNT_POS +: 5] = 5'h04;
		c[CTRL_GO_BIT] = 1'b1;
		lat <= 4'h3;
		clr();
		apb(1'b1, OFS_CTRL, c, v, e);
		apb(1'b1, OFS_CTRL, c, v, e);
		apb(1'b0, OFS_STAT, 32'h0, v, e);
		chk(v, 32'h00000007, "lost, link and busy");
		settle();
		chk(mem_a.size(), 4, "refused start fetched");
		chk(rf_a.size(), 4, "refused start wrote");
		apb(1'b0, OFS_START, 32'h0, v, e);
		chk(v, 32'h00008010, "start readback");
		apb(1'b1, OFS_STAT, 32'h00000004, v, e);
		apb(1'b0, OFS_STAT, 32'h0, v, e);
		chk(v, 32'h00000002, "lost cleared");
	endtask

	// Watchdog well beyond the expected run of under a thousand cycles
	initial begin
		repeat (40000) @(posedge sys_clk_i);
		bad_count++;
		final_report();
	end

	// Reset, then the scenarios in turn
	initial begin
		{rst_n_i, psel_i, penable_i, pwrite_i, alu_we_i, alu_upd_i} = '0;
		{paddr_i, pwdata_i, alu_dest_i, alu_data_i} = '0;
		rf_ready_i = 1'b1;
		lat = 4'h0;
		cyc = 0;
		bad_count = 0;
		tests_run = 0;
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		regs();
		masks();
		bank_cost();
		update();
		refuse();
		final_report();
	end
endmodule
`default_nettype wire
